// ===== design/ccr_channel_cal_regs.sv
// Channel seven configuration and calibration register bank
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - Config bits 15:6 hold a signed ten-bit phase delay in modulator clocks
// - Config bits 5:3 ignore writes and read zero
// - Override bit clear follows global DC-block; set disables filter here only
// - Input select 00 pins, 01 shorted, 10 positive test, 11 negative test
// - Offset-high holds offset bits 23:8, read-write, resets to zero
// - Offset-low upper byte holds offset bits 7:0; low byte reads zero
// - Gain is unsigned 24-bit, 0.0 to under 2.0; gain-high holds 23:8
// - Gain-high resets to 8000h meaning unity; other calibration words reset zero
// - Gain-low upper byte holds gain bits 7:0; low byte ignores writes, reads zero
// - Checksum word is read-only, unaffected by writes, zero after reset
module ccr_channel_cal_regs (
  input  wire logic                            clk_sys,
  input  wire logic                            sys_rst,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [ccr_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  input  wire logic [ccr_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output logic      [1:0]                      s_axi_bresp,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  input  wire logic [ccr_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic      [ccr_pkg::AXI_DATA_W-1:0]  s_axi_rdata,
  output logic      [1:0]                      s_axi_rresp,
  input  wire logic                            globalDcBlockSetting,
  output ccr_pkg::ccr_cfg_t                    channelCfg,
  output logic                                 dcBlockActive,
  output ccr_pkg::ccr_cal_t                    channelCal,
  output logic      [15:0]                     checksumWord
);
  import ccr_pkg::*;

  logic                  wrEn;
  logic [5:0]            wrIndex;
  logic [15:0]           wrData;
  logic [1:0]            wrStrb;
  logic                  wrMapped;
  logic [5:0]            rdIndex;
  logic [15:0]           rdData;
  logic                  rdMapped;
  logic [9:0]            phaseDelay;
  logic                  dcBlockOff;
  ccr_insel_t            inputSelect;
  logic [15:0]           offsetCalHigh;
  logic [7:0]            offsetCalLow;
  logic [15:0]           gainCalHigh;
  logic [7:0]            gainCalLow;
  logic [15:0]           topReserved;
  logic [15:0]           cfgWord;
  logic [15:0]           offsetLowWord;
  logic [15:0]           gainLowWord;
  logic [CRC_WORDS-1:0][15:0] crcWords;
  logic [15:0]           crcValue;
  logic                  bankChanged;
  logic                  wrLo;
  logic                  wrHi;

  // Bus protocol engine
  ccr_axil_port u_port (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wrEn          (wrEn),
    .wrIndex       (wrIndex),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrMapped      (wrMapped),
    .rdIndex       (rdIndex),
    .rdData        (rdData),
    .rdMapped      (rdMapped)
  );

  // Address decode shared by both directions
  function automatic logic isMapped(input logic [5:0] idx);
    isMapped = (idx == IDX_CH7_CONFIG) || (idx == IDX_OFFSET_HIGH) ||
               (idx == IDX_OFFSET_LOW) || (idx == IDX_GAIN_HIGH) ||
               (idx == IDX_GAIN_LOW) || (idx == IDX_CHECKSUM) ||
               (idx == IDX_TOP_RESERVED);
  endfunction

  assign wrMapped = isMapped(wrIndex);
  assign rdMapped = isMapped(rdIndex);
  assign wrLo     = wrEn && wrStrb[0];
  assign wrHi     = wrEn && wrStrb[1];

  // Configuration fields; bits 5:3 have no storage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phaseDelay  <= PHASE_RST;
      dcBlockOff  <= 1'b0;
      inputSelect <= INSEL_PINS;
    end else if (wrIndex == IDX_CH7_CONFIG) begin
      if (wrHi) begin
        phaseDelay[9:2] <= wrData[PHASE_MSB:8];
      end
      if (wrLo) begin
        phaseDelay[1:0] <= wrData[7:PHASE_LSB];
        dcBlockOff      <= wrData[DCOFF_BIT];
        inputSelect     <= ccr_insel_t'(wrData[SEL_MSB:SEL_LSB]);
      end
    end
  end

  // Offset calibration words
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      offsetCalHigh <= OFFSET_HI_RST;
      offsetCalLow  <= OFFSET_LO_RST;
    end else begin
      if (wrIndex == IDX_OFFSET_HIGH) begin
        if (wrLo) begin
          offsetCalHigh[7:0] <= wrData[7:0];
        end
        if (wrHi) begin
          offsetCalHigh[15:8] <= wrData[15:8];
        end
      end
      if (wrIndex == IDX_OFFSET_LOW && wrHi) begin
        offsetCalLow <= wrData[CAL_LO_MSB:CAL_LO_LSB];
      end
    end
  end

  // Gain calibration words
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gainCalHigh <= GAIN_HI_RST;
      gainCalLow  <= GAIN_LO_RST;
    end else begin
      if (wrIndex == IDX_GAIN_HIGH) begin
        if (wrLo) begin
          gainCalHigh[7:0] <= wrData[7:0];
        end
        if (wrHi) begin
          gainCalHigh[15:8] <= wrData[15:8];
        end
      end
      if (wrIndex == IDX_GAIN_LOW && wrHi) begin
        gainCalLow <= wrData[CAL_LO_MSB:CAL_LO_LSB];
      end
    end
  end

  // Top reserved word stores whatever is written
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      topReserved <= RESERVED_RST;
    end else if (wrIndex == IDX_TOP_RESERVED) begin
      if (wrLo) begin
        topReserved[7:0] <= wrData[7:0];
      end
      if (wrHi) begin
        topReserved[15:8] <= wrData[15:8];
      end
    end
  end

  // Readback words with reserved bits forced to zero
  assign cfgWord       = {phaseDelay, 3'b000, dcBlockOff, inputSelect};
  assign offsetLowWord = {offsetCalLow, 8'h00};
  assign gainLowWord   = {gainCalLow, 8'h00};

  // Checksum over the bank, refreshed the edge after a change
  assign crcWords = {cfgWord, offsetCalHigh, offsetLowWord,
                     gainCalHigh, gainLowWord, topReserved};

  ccr_crc16 u_crc (
    .words    (crcWords),
    .crcValue (crcValue)
  );

  // Flag a bank write so the checksum follows one edge later
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bankChanged <= 1'b0;
    end else begin
      bankChanged <= wrEn && wrMapped && (wrIndex != IDX_CHECKSUM);
    end
  end

  // Checksum register, never written by the host
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      checksumWord <= CHECKSUM_RST;
    end else if (bankChanged) begin
      checksumWord <= crcValue;
    end
  end

  // Read multiplexer
  always_comb begin
    unique case (rdIndex)
      IDX_CH7_CONFIG:   rdData = cfgWord;
      IDX_OFFSET_HIGH:  rdData = offsetCalHigh;
      IDX_OFFSET_LOW:   rdData = offsetLowWord;
      IDX_GAIN_HIGH:    rdData = gainCalHigh;
      IDX_GAIN_LOW:     rdData = gainLowWord;
      IDX_CHECKSUM:     rdData = checksumWord;
      IDX_TOP_RESERVED: rdData = topReserved;
      default:          rdData = 16'h0000;
    endcase
  end

  // Settings presented to the channel datapath
  assign channelCfg.channelPhaseDelay  = phaseDelay;
  assign channelCfg.channelDcBlockOff  = dcBlockOff;
  assign channelCfg.channelInputSelect = inputSelect;
  assign dcBlockActive = globalDcBlockSetting && !dcBlockOff;
  assign channelCal.offsetCal = {offsetCalHigh, offsetCalLow};
  assign channelCal.gainCal   = {gainCalHigh, gainCalLow};

endmodule

// ===== design/ccr_pkg.sv
// Shared constants and types for the channel calibration register bank
package ccr_pkg;

  // AXI4-Lite widths and responses
  localparam int          AXI_ADDR_W  = 8;
  localparam int          AXI_DATA_W  = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_CH7_CONFIG   = 6'h2C;
  localparam logic [5:0]  IDX_OFFSET_HIGH  = 6'h2D;
  localparam logic [5:0]  IDX_OFFSET_LOW   = 6'h2E;
  localparam logic [5:0]  IDX_GAIN_HIGH    = 6'h2F;
  localparam logic [5:0]  IDX_GAIN_LOW     = 6'h30;
  localparam logic [5:0]  IDX_CHECKSUM     = 6'h3E;
  localparam logic [5:0]  IDX_TOP_RESERVED = 6'h3F;

  // Field positions of the channel configuration register
  localparam int          PHASE_MSB   = 15;
  localparam int          PHASE_LSB   = 6;
  localparam int          DCOFF_BIT   = 2;
  localparam int          SEL_MSB     = 1;
  localparam int          SEL_LSB     = 0;
  // Calibration low byte sits in bits 15:8
  localparam int          CAL_LO_MSB  = 15;
  localparam int          CAL_LO_LSB  = 8;

  // Reset values
  localparam logic [9:0]  PHASE_RST      = 10'h000;
  localparam logic [15:0] OFFSET_HI_RST  = 16'h0000;
  localparam logic [7:0]  OFFSET_LO_RST  = 8'h00;
  localparam logic [15:0] GAIN_HI_RST    = 16'h8000;
  localparam logic [7:0]  GAIN_LO_RST    = 8'h00;
  localparam logic [15:0] CHECKSUM_RST   = 16'h0000;
  localparam logic [15:0] RESERVED_RST   = 16'h0000;

  // Checksum algorithm: CRC-16 over the bank words
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_SEED  = 16'hFFFF;
  localparam int          CRC_WORDS = 6;

  // Input multiplexer codes
  typedef enum logic [1:0] {
    INSEL_PINS     = 2'b00,
    INSEL_SHORTED  = 2'b01,
    INSEL_TEST_POS = 2'b10,
    INSEL_TEST_NEG = 2'b11
  } ccr_insel_t;

  // Channel configuration carried to the datapath
  typedef struct packed {
    logic signed [9:0] channelPhaseDelay;
    logic              channelDcBlockOff;
    ccr_insel_t        channelInputSelect;
  } ccr_cfg_t;

  // Calibration words carried to the datapath
  typedef struct packed {
    logic signed [23:0] offsetCal;
    logic        [23:0] gainCal;
  } ccr_cal_t;

endpackage

// ===== design/ccr_crc16.sv
// Combinational CRC-16 over the words of the register bank
`timescale 1ns/100ps
module ccr_crc16 (
  input  wire logic [ccr_pkg::CRC_WORDS-1:0][15:0] words,
  output logic      [15:0]                         crcValue
);
  import ccr_pkg::*;

  // Shift every word in, most significant word and bit first
  always_comb begin
    logic [15:0] acc;
    logic        fb;
    acc = CRC_SEED;
    fb  = 1'b0;
    for (int w = CRC_WORDS - 1; w >= 0; w--) begin
      for (int b = 15; b >= 0; b--) begin
        fb  = acc[15] ^ words[w][b];
        acc = {acc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
    end
    crcValue = acc;
  end

endmodule

// ===== design/ccr_axil_port.sv
// AXI4-Lite slave handshake that turns bus traffic into register strobes
`timescale 1ns/100ps
module ccr_axil_port (
  input  wire logic                            clk_sys,
  input  wire logic                            sys_rst,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [ccr_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  input  wire logic [ccr_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output logic      [1:0]                      s_axi_bresp,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  input  wire logic [ccr_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic      [ccr_pkg::AXI_DATA_W-1:0]  s_axi_rdata,
  output logic      [1:0]                      s_axi_rresp,
  output logic                                 wrEn,
  output logic      [5:0]                      wrIndex,
  output logic      [15:0]                     wrData,
  output logic      [1:0]                      wrStrb,
  input  wire logic                            wrMapped,
  output logic      [5:0]                      rdIndex,
  input  wire logic [15:0]                     rdData,
  input  wire logic                            rdMapped
);
  import ccr_pkg::*;

  logic       awHeld;
  logic       wHeld;
  logic [5:0] awIndex;
  logic       rdTake;

  // Each channel accepts while nothing of its kind is held
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrEn          = awHeld && wHeld && !s_axi_bvalid;
  assign wrIndex       = awIndex;
  assign rdTake        = s_axi_arvalid && s_axi_arready;
  assign rdIndex       = s_axi_araddr[7:2];

  // Write address capture
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld  <= 1'b0;
      awIndex <= 6'h00;
    end else if (s_axi_awvalid && !awHeld) begin
      awHeld  <= 1'b1;
      awIndex <= s_axi_awaddr[7:2];
    end else if (wrEn) begin
      awHeld  <= 1'b0;
    end
  end

  // Write data capture, low half only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld  <= 1'b0;
      wrData <= 16'h0000;
      wrStrb <= 2'b00;
    end else if (s_axi_wvalid && !wHeld) begin
      wHeld  <= 1'b1;
      wrData <= s_axi_wdata[15:0];
      wrStrb <= s_axi_wstrb[1:0];
    end else if (wrEn) begin
      wHeld  <= 1'b0;
    end
  end

  // Write response after both halves are in
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer registered on the same edge that takes the address
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rdTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rdData};
      s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== testbench/ccr_checker.sv
// Assertion checker for the channel calibration register bank
`timescale 1ns/100ps
module ccr_checker (
  input wire logic                           clk_sys,
  input wire logic                           sys_rst,
  input wire logic                           s_axi_awvalid,
  input wire logic                           s_axi_awready,
  input wire logic [ccr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                           s_axi_wvalid,
  input wire logic                           s_axi_wready,
  input wire logic [ccr_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0]                     s_axi_wstrb,
  input wire logic                           s_axi_bvalid,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic [ccr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                           s_axi_rvalid,
  input wire logic [ccr_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic                           globalDcBlockSetting,
  input wire ccr_pkg::ccr_cfg_t              channelCfg,
  input wire logic                           dcBlockActive,
  input wire ccr_pkg::ccr_cal_t              channelCal,
  input wire logic [15:0]                    checksumWord
);
  import ccr_pkg::*;
  logic [5:0] rdIdx;
  // Index of the read in flight
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      rdIdx <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rdIdx <= s_axi_araddr[7:2];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Full-word write taken at one edge
  sequence s_wr(idx);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr[7:2] == idx && s_axi_wstrb[1:0] == 2'b11;
  endsequence
  // First cycle of read data for an index
  sequence s_rd(idx);
    $rose(s_axi_rvalid) && rdIdx == idx;
  endsequence
  property p_dc_active;
    dcBlockActive == (globalDcBlockSetting && !channelCfg.channelDcBlockOff);
  endproperty
  a_dc_active: assert property (p_dc_active) else $error("dc block state wrong");
  property p_reset_vals;
    $past(sys_rst) |-> channelCal.gainCal == 24'h80_0000 && channelCal.offsetCal == 24'h00_0000
      && checksumWord == 16'h0000 && channelCfg == 13'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");
  property p_cfg_write;
    s_wr(IDX_CH7_CONFIG) |-> ##2 channelCfg == {$past(s_axi_wdata[15:6], 2),
      $past(s_axi_wdata[2], 2), $past(s_axi_wdata[1:0], 2)};
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config lost");
  property p_cfg_read;
    s_rd(IDX_CH7_CONFIG) |-> s_axi_rdata == {16'h0000, channelCfg.channelPhaseDelay, 3'b000,
      channelCfg.channelDcBlockOff, channelCfg.channelInputSelect};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
  property p_offhi_read;
    s_rd(IDX_OFFSET_HIGH) |-> s_axi_rdata[15:0] == channelCal.offsetCal[23:8];
  endproperty
  a_offhi_read: assert property (p_offhi_read) else $error("offset high wrong");
  property p_gainhi_read;
    s_rd(IDX_GAIN_HIGH) |-> s_axi_rdata[15:0] == channelCal.gainCal[23:8];
  endproperty
  a_gainhi_read: assert property (p_gainhi_read) else $error("gain high wrong");
  property p_low_rsvd;
    $rose(s_axi_rvalid) && (rdIdx == IDX_OFFSET_LOW || rdIdx == IDX_GAIN_LOW)
      |-> s_axi_rdata[7:0] == 8'h00 && s_axi_rdata[15:8] == (rdIdx == IDX_OFFSET_LOW
      ? channelCal.offsetCal[7:0] : channelCal.gainCal[7:0]);
  endproperty
  a_low_rsvd: assert property (p_low_rsvd) else $error("low word readback wrong");
  property p_offlo_write;
    s_wr(IDX_OFFSET_LOW) |-> ##2 channelCal.offsetCal[7:0] == $past(s_axi_wdata[15:8], 2);
  endproperty
  a_offlo_write: assert property (p_offlo_write) else $error("offset low write lost");
  property p_crc_read;
    s_rd(IDX_CHECKSUM) |-> s_axi_rdata == {16'h0000, checksumWord};
  endproperty
  a_crc_read: assert property (p_crc_read) else $error("checksum readback wrong");
  property p_crc_change;
    $changed(checksumWord) |-> $past(s_axi_bvalid);
  endproperty
  a_crc_change: assert property (p_crc_change) else $error("checksum moved alone");
endmodule
bind ccr_channel_cal_regs ccr_checker i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .globalDcBlockSetting(globalDcBlockSetting),
  .channelCfg(channelCfg), .dcBlockActive(dcBlockActive), .channelCal(channelCal),
  .checksumWord(checksumWord));

// ===== testbench/channel_cal_config_regs_bench.sv
// Self-checking bench for the channel calibration register bank
`timescale 1ns/100ps
module channel_cal_config_regs_bench;
  import ccr_pkg::*;
  logic        clk_sys, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, globalDcBlockSetting, dcBlockActive;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] checksumWord;
  ccr_cfg_t    channelCfg;
  ccr_cal_t    channelCal;
  int          errorCnt, checkCount;
  ccr_channel_cal_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'b000), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'b000),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .globalDcBlockSetting(globalDcBlockSetting),
    .channelCfg(channelCfg), .dcBlockActive(dcBlockActive), .channelCal(channelCal),
    .checksumWord(checksumWord));
  // Clock generator
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait ran out
  task automatic give_up();
    errorCnt++;
    $display("ERROR at %0t: bus answer missing", $time);
    conclude();
  endtask
  // One register write with response
  task automatic reg_write(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] st,
                           output logic [1:0] resp);
    int n;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= {2'b00, st};
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      give_up();
  endtask
  // One register read
  task automatic reg_read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      give_up();
  endtask
  // Reference checksum over the readback words
  function automatic logic [15:0] crc_of(input logic [15:0] w [6]);
    logic [15:0] c;
    c = CRC_SEED;
    for (int k = 0; k < 6; k++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k][b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // Reset values of every word, unmapped index refused
  task automatic t_reset_values();
    logic [5:0]  ix [8] = '{IDX_CH7_CONFIG, IDX_OFFSET_HIGH, IDX_OFFSET_LOW, IDX_GAIN_HIGH,
                            IDX_GAIN_LOW, IDX_CHECKSUM, IDX_TOP_RESERVED, 6'h31};
    logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
                            16'h0000, 16'h0000};
    logic [31:0] rd;
    logic [1:0]  rs;
    for (int i = 0; i < 8; i++) begin
      reg_read(ix[i], rd, rs);
      check(rd, {16'h0000, rv[i]});
      check({30'h0, rs}, {30'h0, (i == 7) ? RESP_DECERR : RESP_OKAY});
    end
    reg_write(6'h31, 16'hFFFF, 2'b11, rs);
    check({30'h0, rs}, {30'h0, RESP_DECERR});
  endtask
  // Phase, override and every input select code
  task automatic t_config();
    logic [9:0]  ph [4] = '{10'h200, 10'h1FF, 10'h3FF, 10'h001};
    logic [15:0] d;
    logic [31:0] rd;
    logic [1:0]  rs;
    for (int i = 0; i < 4; i++) begin
      d = {ph[i], 3'b111, i[0], i[1:0]};
      globalDcBlockSetting <= i[1];
      reg_write(IDX_CH7_CONFIG, d, 2'b11, rs);
      reg_read(IDX_CH7_CONFIG, rd, rs);
      check(rd, {16'h0000, d & 16'hFFC7});
      check({30'h0, channelCfg.channelInputSelect}, {30'h0, i[1:0]});
      check({22'h0, channelCfg.channelPhaseDelay}, {22'h0, ph[i]});
      check({31'h0, dcBlockActive}, {31'h0, i[1] & ~i[0]});
    end
  endtask
  // Calibration words, split halves and byte strobes
  task automatic t_cal();
    logic [31:0] rd;
    logic [1:0]  rs;
    reg_write(IDX_OFFSET_HIGH, 16'h8001, 2'b11, rs);
    reg_write(IDX_OFFSET_LOW, 16'hA5FF, 2'b11, rs);
    reg_write(IDX_GAIN_HIGH, 16'hFFFF, 2'b11, rs);
    reg_write(IDX_GAIN_LOW, 16'h7E3C, 2'b11, rs);
    check({8'h00, channelCal.offsetCal}, 32'h0080_01A5);
    check({8'h00, channelCal.gainCal}, 32'h00FF_FF7E);
    reg_read(IDX_OFFSET_LOW, rd, rs);
    check(rd, 32'h0000_A500);
    reg_write(IDX_GAIN_LOW, 16'h00FF, 2'b01, rs);
    reg_read(IDX_GAIN_LOW, rd, rs);
    check(rd, 32'h0000_7E00);
    reg_write(IDX_GAIN_LOW, 16'h1234, 2'b10, rs);
    check({8'h00, channelCal.gainCal}, 32'h00FF_FF12);
  endtask
  // Checksum follows the bank and ignores host writes
  task automatic t_crc();
    logic [5:0]  ix [6] = '{IDX_CH7_CONFIG, IDX_OFFSET_HIGH, IDX_OFFSET_LOW, IDX_GAIN_HIGH,
                            IDX_GAIN_LOW, IDX_TOP_RESERVED};
    logic [15:0] wv [6] = '{16'hABCD, 16'h1357, 16'h9BFF, 16'h8000, 16'h4411, 16'h0000};
    logic [15:0] vw [6] = '{16'hABC5, 16'h1357, 16'h9B00, 16'h8000, 16'h4400, 16'h0000};
    logic [31:0] rd;
    logic [1:0]  rs;
    for (int i = 0; i < 6; i++)
      reg_write(ix[i], wv[i], 2'b11, rs);
    reg_read(IDX_CHECKSUM, rd, rs);
    check(rd, {16'h0000, crc_of(vw)});
    reg_write(IDX_CHECKSUM, 16'h5AA5, 2'b11, rs);
    check({30'h0, rs}, {30'h0, RESP_OKAY});
    reg_read(IDX_CHECKSUM, rd, rs);
    check(rd, {16'h0000, crc_of(vw)});
    check({16'h0000, checksumWord}, {16'h0000, crc_of(vw)});
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    globalDcBlockSetting = 1'b0;
    errorCnt = 0;
    checkCount = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_values();
    t_config();
    t_cal();
    t_crc();
    conclude();
  end
endmodule
